// File: core/lbd_pkg.sv
// Purpose: Shared constants and types for the LED backlight dimming and fault controller
// Assumes: 20 MHz control clock, AXI4-Lite register access
// Notes:   Times are kept in their own unit; cycle counts are derived from them

`default_nettype none

package lbd_pkg;

	// ==========================================================
	// Clock and times
	localparam int CLK_HZ          = 20_000_000;
	localparam int CYC_PER_US      = CLK_HZ / 1_000_000;
	localparam int SCAN_TIME_US    = 4200;
	localparam int FAULT_TIME_US   = 65000;
	localparam int FAULT_LOW_US    = 8125;
	localparam int MIN_ON_US       = 50;
	localparam int SCAN_CYCLES     = SCAN_TIME_US * CYC_PER_US;
	localparam int FAULT_CYCLES    = FAULT_TIME_US * CYC_PER_US;
	localparam int FAULT_LOW_CYCLES = FAULT_LOW_US * CYC_PER_US;
	localparam int MIN_ON_CYCLES   = MIN_ON_US * CYC_PER_US;

	// ==========================================================
	// Switching frequencies
	localparam int FSW_LOW_KHZ     = 500;
	localparam int FSW_MID_KHZ     = 750;
	localparam int FSW_HIGH_KHZ    = 1000;
	localparam logic [5:0] SW_PER_LOW  = 6'(CLK_HZ / (FSW_LOW_KHZ * 1000));
	localparam logic [5:0] SW_PER_MID  = 6'(CLK_HZ / (FSW_MID_KHZ * 1000));
	localparam logic [5:0] SW_PER_HIGH = 6'(CLK_HZ / (FSW_HIGH_KHZ * 1000));
	localparam logic [1:0] FREQ_LOW    = 2'h0;
	localparam logic [1:0] FREQ_MID    = 2'h1;
	localparam logic [1:0] FREQ_HIGH   = 2'h2;

	// ==========================================================
	// Dimming
	localparam int NSTR              = 6;
	localparam logic [7:0] AMP_FULL  = 8'hFF;
	localparam logic [7:0] AMP_KNEE  = 8'h20;
	localparam logic [19:0] PER_MAX  = 20'hF_FFFF;

	// ==========================================================
	// Register map
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_DIM    = 8'h08;
	localparam logic       CTRL_RST   = 1'h1;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		LBD_OFF,
		LBD_LOCKOUT,
		LBD_SCAN,
		LBD_RUN,
		LBD_FAULT
	} lbd_state_e;

endpackage : lbd_pkg

`default_nettype wire

// File: core/lbd_ctrl.sv
// Purpose: Control logic of a six-string LED backlight driver
// Assumes: Comparator outputs arrive as asynchronous single-bit pins
// Notes:   Registers reached over AXI4-Lite; long counts are parameters

`timescale 1ns/1ps
`default_nettype none

// Contract
// - Hold controller off until supply passes lockout, with hysteresis before dropping.
// - Sample each feedback at power-up; grounded strings get current source disabled.
// - Finish the 4.2 ms string scan before the converter may switch.
// - After scan, string enables stay fixed despite later grounding.
// - Shutdown low turns off regulator, reference, current sources and control.
// - Tri-level select: ground 500, open 750, supply 1000 kHz.
// - Overvoltage asserted keeps switch off until output falls below threshold.
// - Current sources switch within 10 us, supporting 2 kHz dimming.
// - Over enabled strings derive highest level for fault, lowest for regulation.
// - Highest level over threshold past timeout latches fault; regulator stays on.
// - Direct pulse mode timeout is base interval divided by duty.
// - Analog mode: fixed timeout above 12.5%, else 8.125 ms over duty.
// - Mode input high selects analog dimming, low selects direct pulse.
// - Analog: duty sets amplitude above 12.5%, pulse-modulated below.
// - Direct mode: brightness gates converter and sources at full amplitude.
// - Pulsed current turn-on aligns with brightness input edge.
// - Sources off during converter off-time; output not discharged.
// - Direct mode ignores loop, runs 100 Hz to 2 kHz, minimum on-time applies.
// - Mode low with loop capacitor: duty tracking continues without affecting dimming.
module lbd_ctrl #(
	parameter int SCAN_CYC      = lbd_pkg::SCAN_CYCLES,
	parameter int FAULT_CYC     = lbd_pkg::FAULT_CYCLES,
	parameter int FAULT_LOW_CYC = lbd_pkg::FAULT_LOW_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        supply_above_on,
	input  wire logic        supply_above_off,
	input  wire logic        shutdown_n_input,
	input  wire logic        freq_sel_above_low,
	input  wire logic        freq_sel_above_high,
	input  wire logic        output_overvolt_sense,
	input  wire logic        brightness_pwm_in,
	input  wire logic        dim_mode_select,
	input  wire logic [5:0]  string_feedback_grounded,
	input  wire logic [5:0]  string_feedback_over,
	input  wire logic [5:0]  string_feedback_below,
	output logic             regulator_enable,
	output logic             control_enable,
	output logic             boost_switch,
	output logic [5:0]       string_source_on,
	output logic [7:0]       dim_amplitude,
	output logic [1:0]       freq_code,
	output logic             highest_string_level,
	output logic             lowest_string_level,
	output logic             fault_latched
);

	// ==========================================================
	// Pin synchronisers
	localparam int NPIN = 26;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_m;
	logic [NPIN-1:0] pin_s;

	assign pin_raw = {string_feedback_below, string_feedback_over, string_feedback_grounded,
		dim_mode_select, brightness_pwm_in, output_overvolt_sense, freq_sel_above_high,
		freq_sel_above_low, shutdown_n_input, supply_above_off, supply_above_on};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_m <= '0;
			pin_s <= '0;
		end else begin
			pin_m <= pin_raw;
			pin_s <= pin_m;
		end
	end

	logic       sup_on;
	logic       sup_off;
	logic       shutdown_n_input_n;
	logic       fs_lo;
	logic       fs_hi;
	logic       ov;
	logic       bright;
	logic       analog;
	logic [5:0] fb_gnd;
	logic [5:0] fb_over;
	logic [5:0] fb_below;

	assign {fb_below, fb_over, fb_gnd, analog, bright, ov, fs_hi, fs_lo, shutdown_n_input_n, sup_off, sup_on} = pin_s;

	// ==========================================================
	// Helpers
	function automatic logic [5:0] sw_period(input logic [1:0] code);
		if (code == lbd_pkg::FREQ_LOW) begin
			sw_period = lbd_pkg::SW_PER_LOW;
		end else if (code == lbd_pkg::FREQ_HIGH) begin
			sw_period = lbd_pkg::SW_PER_HIGH;
		end else begin
			sw_period = lbd_pkg::SW_PER_MID;
		end
	endfunction : sw_period

	function automatic logic [1:0] reg_sel(input logic [7:0] addr);
		if (addr == lbd_pkg::REG_CTRL) begin
			reg_sel = 2'h0;
		end else if (addr == lbd_pkg::REG_STATUS) begin
			reg_sel = 2'h1;
		end else if (addr == lbd_pkg::REG_DIM) begin
			reg_sel = 2'h2;
		end else begin
			reg_sel = 2'h3;
		end
	endfunction : reg_sel

	// ==========================================================
	// Supply lockout with hysteresis
	logic supply_ok;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			supply_ok <= 1'b0;
		end else if (sup_on) begin
			supply_ok <= 1'b1;
		end else if (!sup_off) begin
			supply_ok <= 1'b0;
		end
	end

	// ==========================================================
	// Main sequence
	lbd_pkg::lbd_state_e state;
	logic [20:0]         scan_cnt;
	logic [5:0]          string_en;
	logic [20:0]         fault_cnt;
	logic                duty_above;
	logic                fault_trip;

	assign fault_trip = (!analog || duty_above) ? (fault_cnt >= 21'(FAULT_CYC))
		: (fault_cnt >= 21'(FAULT_LOW_CYC));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state     <= lbd_pkg::LBD_OFF;
			scan_cnt  <= '0;
			string_en <= '0;
		end else if (!shutdown_n_input_n) begin
			state <= lbd_pkg::LBD_OFF;
		end else if (!supply_ok) begin
			state <= lbd_pkg::LBD_LOCKOUT;
		end else begin
			case (state)
				lbd_pkg::LBD_OFF, lbd_pkg::LBD_LOCKOUT: begin
					state    <= lbd_pkg::LBD_SCAN;
					scan_cnt <= '0;
				end
				lbd_pkg::LBD_SCAN: begin
					if (scan_cnt >= 21'(SCAN_CYC - 1)) begin
						string_en <= ~fb_gnd;
						state     <= lbd_pkg::LBD_RUN;
					end else begin
						scan_cnt <= scan_cnt + 21'h0_0001;
					end
				end
				lbd_pkg::LBD_RUN: begin
					if (fault_trip) begin
						state <= lbd_pkg::LBD_FAULT;
					end
				end
				default: begin
					state <= state;
				end
			endcase
		end
	end

	// ==========================================================
	// Brightness duty measurement
	logic        bright_d;
	logic [19:0] per_cnt;
	logic [19:0] hi_cnt;
	logic [19:0] per_lat;
	logic [19:0] rem;
	logic [20:0] rem2;
	logic [3:0]  div_cnt;
	logic [7:0]  quo;
	logic [7:0]  duty;
	logic        rise;
	logic        fall;

	assign rise = bright && !bright_d;
	assign fall = !bright && bright_d;
	assign rem2 = {rem, 1'b0};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bright_d   <= 1'b0;
			per_cnt    <= '0;
			hi_cnt     <= '0;
			per_lat    <= '0;
			rem        <= '0;
			div_cnt    <= '0;
			quo        <= '0;
			duty       <= '0;
			duty_above <= 1'b0;
		end else begin
			bright_d <= bright;
			if (rise) begin
				per_cnt    <= 20'h0_0001;
				hi_cnt     <= 20'h0_0001;
				per_lat    <= per_cnt;
				rem        <= hi_cnt;
				div_cnt    <= 4'h8;
				quo        <= '0;
				duty_above <= {hi_cnt, 3'b000} > {3'b000, per_cnt};
			end else if (per_cnt == lbd_pkg::PER_MAX) begin
				duty       <= bright ? lbd_pkg::AMP_FULL : 8'h00;
				duty_above <= bright;
			end else begin
				per_cnt <= per_cnt + 20'h0_0001;
				if (bright) begin
					hi_cnt <= hi_cnt + 20'h0_0001;
				end
			end
			if (div_cnt != 4'h0) begin
				div_cnt <= div_cnt - 4'h1;
				if (rem2 >= {1'b0, per_lat}) begin
					rem <= 20'(rem2 - {1'b0, per_lat});
					quo <= {quo[6:0], 1'b1};
				end else begin
					rem <= rem2[19:0];
					quo <= {quo[6:0], 1'b0};
				end
			end
			if (div_cnt == 4'h1) begin
				duty <= {quo[6:0], rem2 >= {1'b0, per_lat}};
			end
		end
	end

	// ==========================================================
	// Dimming gate
	logic        pulse_on;
	logic [10:0] on_cnt;
	logic        steady;
	logic        gate;

	assign steady = analog && duty_above;
	assign gate   = steady || pulse_on;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pulse_on <= 1'b0;
			on_cnt   <= '0;
		end else if (rise) begin
			pulse_on <= 1'b1;
			on_cnt   <= '0;
		end else begin
			if (on_cnt < 11'(lbd_pkg::MIN_ON_CYCLES)) begin
				on_cnt <= on_cnt + 11'h001;
			end
			if (!bright && on_cnt >= 11'(lbd_pkg::MIN_ON_CYCLES)) begin
				pulse_on <= 1'b0;
			end
		end
	end

	// ==========================================================
	// String levels and fault timer
	logic count_en;

	assign count_en = (analog && duty_above) ? 1'b1 : bright;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			highest_string_level <= 1'b0;
			lowest_string_level  <= 1'b0;
			fault_cnt            <= '0;
		end else begin
			highest_string_level <= |(fb_over & string_en);
			lowest_string_level  <= |(fb_below & string_en);
			if (state != lbd_pkg::LBD_RUN || !highest_string_level) begin
				fault_cnt <= '0;
			end else if (count_en && !fault_trip) begin
				fault_cnt <= fault_cnt + 21'h00_0001;
			end
		end
	end

	// ==========================================================
	// Converter switching and outputs
	logic [5:0] sw_cnt;
	logic [5:0] sw_per;
	logic       ctrl_run;
	logic       running;
	logic [1:0] fcode;

	assign running = state == lbd_pkg::LBD_RUN;
	assign fcode = !fs_lo ? lbd_pkg::FREQ_LOW : (fs_hi ? lbd_pkg::FREQ_HIGH : lbd_pkg::FREQ_MID);
	assign sw_per = sw_period(fcode);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_cnt           <= '0;
			freq_code        <= lbd_pkg::FREQ_LOW;
			boost_switch     <= 1'b0;
			string_source_on <= '0;
			dim_amplitude    <= '0;
			regulator_enable <= 1'b0;
			control_enable   <= 1'b0;
			fault_latched    <= 1'b0;
		end else begin
			freq_code <= fcode;
			if (sw_cnt >= sw_per - 6'h01) begin
				sw_cnt <= '0;
			end else begin
				sw_cnt <= sw_cnt + 6'h01;
			end
			boost_switch <= running && ctrl_run && gate && !ov && lowest_string_level
				&& (sw_cnt < {1'b0, sw_per[5:1]});
			string_source_on <= (running && ctrl_run && gate) ? string_en : 6'h00;
			if (!analog) begin
				dim_amplitude <= lbd_pkg::AMP_FULL;
			end else if (duty_above) begin
				dim_amplitude <= duty;
			end else begin
				dim_amplitude <= lbd_pkg::AMP_KNEE;
			end
			regulator_enable <= shutdown_n_input_n;
			control_enable   <= shutdown_n_input_n && supply_ok && state != lbd_pkg::LBD_FAULT;
			fault_latched    <= state == lbd_pkg::LBD_FAULT;
		end
	end

	// ==========================================================
	// AXI4-Lite slave
	logic        aw_got;
	logic        w_got;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic [31:0] status;

	assign status = {8'h00, duty, 1'b0, analog, lowest_string_level, highest_string_level,
		freq_code, string_en, fault_latched, state};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= lbd_pkg::RESP_OKAY;
			ctrl_run      <= lbd_pkg::CTRL_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got        <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got        <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_got && w_got && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (reg_sel(aw_addr) == 2'h3) ? lbd_pkg::RESP_SLVERR : lbd_pkg::RESP_OKAY;
				if (reg_sel(aw_addr) == 2'h0 && w_strb[0]) begin
					ctrl_run <= w_data[0];
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_got        <= 1'b0;
				w_got         <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= lbd_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= lbd_pkg::RESP_OKAY;
			if (reg_sel(s_axi_araddr) == 2'h0) begin
				s_axi_rdata <= {31'h0000_0000, ctrl_run};
			end else if (reg_sel(s_axi_araddr) == 2'h1) begin
				s_axi_rdata <= status;
			end else if (reg_sel(s_axi_araddr) == 2'h2) begin
				s_axi_rdata <= {24'h00_0000, dim_amplitude};
			end else begin
				s_axi_rdata <= '0;
				s_axi_rresp <= lbd_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule : lbd_ctrl

`default_nettype wire

// File: bench/lbd_far_model.sv
// Purpose: Brightness source and LED string model facing the backlight controller
// Assumes: Period and high time are given in clock cycles
// Notes:   An open string drags the level of healthy strings over the fault mark
`timescale 1ns/1ps
`default_nettype none

module lbd_far_model (
	input  wire logic        aclk,
	input  wire logic        run,
	input  wire logic [15:0] period,
	input  wire logic [15:0] high,
	input  wire logic [5:0]  grounded,
	input  wire logic [5:0]  open,
	output logic             brightness_pwm_in,
	output logic [5:0]       string_feedback_over,
	output logic [5:0]       string_feedback_below
);
	logic [15:0] phase = 16'h0000;
	logic        bright = 1'b0;

	// ==========================================================
	// Brightness source
	// steady frequency
	always @(posedge aclk) begin
		phase <= (!run || phase >= period - 16'h0001) ? 16'h0000 : phase + 16'h0001;
		bright <= run && (phase < high);
	end
	assign brightness_pwm_in = bright;

	// ==========================================================
	// Strings: every string in use asks for headroom
	assign string_feedback_below = ~grounded;
	assign string_feedback_over  = (open != 6'h00) ? ~grounded & ~open : 6'h00;
endmodule : lbd_far_model

`default_nettype wire

// File: bench/lbd_ctrl_checker.sv
// Purpose: Port-level assertions for the backlight controller
// Assumes: Pins pass a two-flop synchroniser before use
// Notes:   Repetition counts leave room for the synchroniser and output register
`timescale 1ns/1ps
`default_nettype none

module lbd_ctrl_checker #(
	parameter int SCAN_CYC = 50
) (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       shutdown_n_input,
	input wire logic       supply_above_on,
	input wire logic       supply_above_off,
	input wire logic       output_overvolt_sense,
	input wire logic       freq_sel_above_low,
	input wire logic       freq_sel_above_high,
	input wire logic       dim_mode_select,
	input wire logic [5:0] string_feedback_over,
	input wire logic       regulator_enable,
	input wire logic       control_enable,
	input wire logic       boost_switch,
	input wire logic [5:0] string_source_on,
	input wire logic [7:0] dim_amplitude,
	input wire logic [1:0] freq_code,
	input wire logic       highest_string_level,
	input wire logic       fault_latched
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ==========================================================
	// Cycles since the controller was enabled
	logic [31:0] on_cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn || !control_enable) on_cnt <= 32'h0000_0000;
		else if (on_cnt < 32'hFFFF_0000) on_cnt <= on_cnt + 32'h0000_0001;
	end

	property p_shutdown_off;
		!shutdown_n_input [*6] |-> !regulator_enable && !control_enable && string_source_on == 6'h00;
	endproperty
	a_shutdown_off: assert property (p_shutdown_off) else $error("outputs active in shutdown");
	property p_lockout;
		(!supply_above_on && !supply_above_off) [*6] |-> !control_enable && !boost_switch;
	endproperty
	a_lockout: assert property (p_lockout) else $error("controller active below lockout");
	property p_scan_first;
		boost_switch || string_source_on != 6'h00 |-> on_cnt + 32'h0000_0002 >= SCAN_CYC;
	endproperty
	a_scan_first: assert property (p_scan_first) else $error("switching before scan end");
	property p_ov_cut;
		output_overvolt_sense [*6] |-> !boost_switch;
	endproperty
	a_ov_cut: assert property (p_ov_cut) else $error("switch on during overvoltage");
	property p_freq;
		$stable({freq_sel_above_high, freq_sel_above_low}) [*6] |-> freq_code ==
			(!freq_sel_above_low ? lbd_pkg::FREQ_LOW :
			(freq_sel_above_high ? lbd_pkg::FREQ_HIGH : lbd_pkg::FREQ_MID));
	endproperty
	a_freq: assert property (p_freq) else $error("frequency code wrong");
	property p_fault_off;
		fault_latched [*2] |-> !control_enable && !boost_switch && string_source_on == 6'h00;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("active while fault latched");
	property p_direct_full;
		!dim_mode_select [*6] ##0 string_source_on != 6'h00 |-> dim_amplitude == lbd_pkg::AMP_FULL;
	endproperty
	a_direct_full: assert property (p_direct_full) else $error("direct pulse amplitude not full");
	property p_highest;
		string_feedback_over == 6'h00 [*6] |-> !highest_string_level;
	endproperty
	a_highest: assert property (p_highest) else $error("highest level without cause");
endmodule : lbd_ctrl_checker

bind lbd_ctrl lbd_ctrl_checker #(.SCAN_CYC(SCAN_CYC)) u_chk (.aclk, .aresetn, .shutdown_n_input, .supply_above_on,
	.supply_above_off, .output_overvolt_sense, .freq_sel_above_low, .freq_sel_above_high, .dim_mode_select,
	.string_feedback_over, .regulator_enable, .control_enable, .boost_switch, .string_source_on, .dim_amplitude,
	.freq_code, .highest_string_level, .fault_latched);

`default_nettype wire

// File: bench/led_backlight_dim_fault_ctrl_test.sv
// Purpose: Self-checking bench for the backlight controller
// Assumes: Shortened scan and fault counts, brightness period of 2 kHz
// Notes:   Random values come from an xorshift with a fixed seed
`timescale 1ns/1ps
`default_nettype none

module led_backlight_dim_fault_ctrl_test;
	localparam int SCAN = 50;
	localparam int FLT  = 400;
	localparam int PER  = 10000;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000, rdata, seed = 32'h0000_D2EA;
	logic        awready, wready, bvalid, arready, rvalid, bright, reg_en, ctl_en, boost, hsl, lsl, flt;
	logic [1:0]  bresp, rresp, fcode;
	logic        sup = 1'b0, shutdown_n_input_n = 1'b0, f_lo = 1'b0, f_hi = 1'b0, ov = 1'b0, mode = 1'b1, run = 1'b0;
	logic [15:0] high = 16'h0000;
	logic [5:0]  gnd = 6'h00, open_m = 6'h00, en = 6'h00, over, below, src_on;
	logic [7:0]  amp;
	int          errors = 0, tests_run = 0;

	lbd_ctrl #(.SCAN_CYC(SCAN), .FAULT_CYC(FLT), .FAULT_LOW_CYC(100)) uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .supply_above_on(sup), .supply_above_off(sup), .shutdown_n_input(shutdown_n_input_n),
		.freq_sel_above_low(f_lo), .freq_sel_above_high(f_hi), .output_overvolt_sense(ov),
		.brightness_pwm_in(bright), .dim_mode_select(mode), .string_feedback_grounded(gnd),
		.string_feedback_over(over), .string_feedback_below(below), .regulator_enable(reg_en),
		.control_enable(ctl_en), .boost_switch(boost), .string_source_on(src_on), .dim_amplitude(amp),
		.freq_code(fcode), .highest_string_level(hsl), .lowest_string_level(lsl), .fault_latched(flt));
	lbd_far_model far (.aclk(aclk), .run(run), .period(16'(PER)), .high(high), .grounded(gnd), .open(open_m),
		.brightness_pwm_in(bright), .string_feedback_over(over), .string_feedback_below(below));

	initial begin
		forever #25 aclk = ~aclk;
	end

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [31:0] status(input logic [2:0] st, input logic [5:0] e);
		return {22'h0, e, 1'b0, st};
	endfunction : status
	function automatic logic [7:0] exp_amp(input int h);
		return (h * 8 > PER) ? 8'(h * 256 / PER) : lbd_pkg::AMP_KNEE;
	endfunction : exp_amp
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : chk
	task automatic report_and_stop();
		if (errors == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// Register bus master
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask : wr_chk
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk("rdata", exp & m, rdata & m);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask : rd_chk
	task automatic boost_count(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge aclk);
			c += (boost === 1'b1);
		end
	endtask : boost_count

	// ==========================================================
	// Scenarios
	initial begin
		logic [1:0] fc[3];
		int khz[3];
		int n;
		int h;
		time t0;
		fc = '{lbd_pkg::FREQ_LOW, lbd_pkg::FREQ_MID, lbd_pkg::FREQ_HIGH};
		khz = '{lbd_pkg::FSW_LOW_KHZ, lbd_pkg::FSW_MID_KHZ, lbd_pkg::FSW_HIGH_KHZ};
		tick(6);
		aresetn <= 1'b1;
		rd_chk(lbd_pkg::REG_CTRL, 32'h0000_0001, 32'h0000_0001, lbd_pkg::RESP_OKAY);
		rd_chk(lbd_pkg::REG_STATUS, status(3'h0, 6'h00), 32'h0000_0007, lbd_pkg::RESP_OKAY);
		rd_chk(8'h0C, 32'h0000_0000, 32'hFFFF_FFFF, lbd_pkg::RESP_SLVERR);
		wr_chk(8'h0C, 32'h0000_0000, lbd_pkg::RESP_SLVERR);
		seed = xs(seed);
		gnd <= seed[5:0] & 6'h3C;
		en <= ~(seed[5:0] & 6'h3C);
		high <= 16'd5000;
		run <= 1'b1;
		sup <= 1'b1;
		shutdown_n_input_n <= 1'b1;
		tick(8);
		rd_chk(lbd_pkg::REG_STATUS, status(3'h2, 6'h00), 32'h0000_0007, lbd_pkg::RESP_OKAY);
		chk("boost", 32'h0, {31'h0, boost});
		tick(SCAN + 20);
		rd_chk(lbd_pkg::REG_STATUS, status(3'h3, en), 32'h0000_03FF, lbd_pkg::RESP_OKAY);
		chk("lowest", 32'h1, {31'h0, lsl});
		gnd <= 6'h3F;
		tick(10);
		rd_chk(lbd_pkg::REG_STATUS, status(3'h3, en), 32'h0000_03FF, lbd_pkg::RESP_OKAY);
		chk("lowest", 32'h0, {31'h0, lsl});
		gnd <= ~en;
		for (int i = 0; i < 3; i++) begin
			f_lo <= (i != 0);
			f_hi <= (i == 2);
			tick(8);
			chk("freq_code", {30'h0, fc[i]}, {30'h0, fcode});
			@(posedge boost);
			t0 = $time;
			@(posedge boost);
			chk("boost period", lbd_pkg::CLK_HZ / (khz[i] * 1000), ($time - t0) / 50);
		end
		ov <= 1'b1;
		tick(8);
		boost_count(100, n);
		chk("boost in overvoltage", 32'h0, n);
		ov <= 1'b0;
		tick(8);
		boost_count(100, n);
		chk("boost resumes", 32'h1, {31'h0, n > 0});
		wr_chk(lbd_pkg::REG_CTRL, 32'h0000_0000, lbd_pkg::RESP_OKAY);
		tick(6);
		boost_count(100, n);
		chk("boost stopped", 32'h0, n);
		rd_chk(lbd_pkg::REG_CTRL, 32'h0000_0000, 32'h0000_0001, lbd_pkg::RESP_OKAY);
		wr_chk(lbd_pkg::REG_CTRL, 32'h0000_0001, lbd_pkg::RESP_OKAY);
		seed = xs(seed);
		for (int k = 0; k < 2; k++) begin
			h = (k == 0) ? 625 * (3 + seed % 13) : 625;
			high <= 16'(h);
			tick(2 * PER + 50);
			chk("amplitude", {24'h0, exp_amp(h)}, {24'h0, amp});
			rd_chk(lbd_pkg::REG_DIM, {24'h0, exp_amp(h)}, 32'h0000_00FF, lbd_pkg::RESP_OKAY);
			@(negedge bright);
			tick(1100);
			chk("analog sources", (k == 0) ? en : 6'h00, src_on);
		end
		mode <= 1'b0;
		high <= 16'd3000;
		repeat (2) begin
			@(posedge bright);
			tick(5);
			chk("direct on", en, src_on);
			chk("direct amplitude", lbd_pkg::AMP_FULL, amp);
			@(negedge bright);
			tick(5);
			chk("direct off", 6'h00, src_on);
		end
		mode <= 1'b1;
		high <= 16'd5000;
		tick(PER);
		open_m <= en & ~(en - 6'h01);
		tick(FLT - 10);
		chk("early fault", 32'h0, {31'h0, flt});
		tick(30);
		chk("fault", 32'h1, {31'h0, flt});
		chk("regulator kept", 32'h1, {31'h0, reg_en});
		shutdown_n_input_n <= 1'b0;
		open_m <= 6'h00;
		tick(10);
		shutdown_n_input_n <= 1'b1;
		tick(SCAN + 20);
		chk("fault cleared", 32'h0, {31'h0, flt});
		mode <= 1'b0;
		run <= 1'b0;
		open_m <= en & ~(en - 6'h01);
		tick(3 * FLT);
		chk("no fault at zero duty", 32'h0, {31'h0, flt});
		run <= 1'b1;
		tick(PER);
		chk("direct fault", 32'h1, {31'h0, flt});
		sup <= 1'b0;
		tick(8);
		rd_chk(lbd_pkg::REG_STATUS, status(3'h1, 6'h00), 32'h0000_000F, lbd_pkg::RESP_OKAY);
		chk("lockout", 32'h0, {31'h0, ctl_en});
		report_and_stop();
	end

	initial begin
		tick(110000);
		errors++;
		report_and_stop();
	end
endmodule : led_backlight_dim_fault_ctrl_test

`default_nettype wire
